// File: core/scc_consts.svh
/*
  Constants for the configuration cell CRC checker: polynomial, instruction code, widths, reset values.
  Assumes inclusion by bare name from the package only; the design modules import the package.
*/
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH
`define SCC_CRC_POLY        32'h04c11db7
`define SCC_CRC_INIT        32'hffffffff
`define SCC_CRC_W           32
`define SCC_FRAME_CRC_W     16
`define SCC_FRAME_POLY      16'h1021
`define SCC_FRAME_INIT      16'hffff
`define SCC_INSTR_W         10
`define SCC_INSTR_LOAD_REF  10'h015
`define SCC_ZERO32          32'h00000000
`endif

// File: core/scc_pkg.sv
/*
  Types shared by the checker modules.
  Assumes scc_consts.svh is on the include path.
*/
package scc_pkg;
  `include "scc_consts.svh"

  typedef enum logic [1:0] {
    SCC_ST_CONFIG = 2'b00,
    SCC_ST_FAILED = 2'b01,
    SCC_ST_USER   = 2'b10
  } scc_mode_type;

  typedef struct packed {
    logic       valid;
    logic       data;
    logic       last;
  } scc_bit_type;

  typedef struct packed {
    logic       capture;
    logic       shift;
    logic       update;
    logic       tdi;
  } scc_tap_type;

  function automatic logic [31:0] scc_crc32_step(input logic [31:0] crc, input logic din);
    logic fb;
    fb = crc[31] ^ din;
    scc_crc32_step = {crc[30:0], 1'b0} ^ (fb ? `SCC_CRC_POLY : `SCC_ZERO32);
  endfunction

  function automatic logic [15:0] scc_crc16_step(input logic [15:0] crc, input logic din);
    logic fb;
    fb = crc[15] ^ din;
    scc_crc16_step = {crc[14:0], 1'b0} ^ (fb ? `SCC_FRAME_POLY : 16'h0000);
  endfunction
endpackage

// File: core/scc_cell_mem.sv
/*
  Configuration cell memory: one bit per address, written during loading, read one bit per clock.
  Assumes a single clock; read data come from a register one cycle after the address.
*/
`timescale 1ns/1ps
module scc_cell_mem
  import scc_pkg::*;
#(
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic          wdata,
  input  wire logic [AW-1:0] raddr,
  output logic               rdata
);
  logic mem [DEPTH];

  initial begin
    if (DEPTH < 2 || (1 << AW) < DEPTH) begin
      $error("scc_cell_mem depth does not fit the address width");
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// File: core/scc_crc_check.sv
/*
  Configuration cell soft error checker: per-frame check while loading, reference capture at the end,
  endless whole-image CRC passes in user mode, and a test access port path to the reference store.
  Assumes the loader streams bits synchronous to clk, and a tap controller gives decoded state strobes.
*/
// Overview of operation
// - Check each loaded frame against its CRC.
// - Load frames until mismatch or all checked.
// - Capture image CRC into reference store.
// - User mode recomputes CRC, compares to reference.
// - Checking runs until reconfiguration request low.
// - Only configuration cells are covered.
// - One 32-bit IEEE 802 CRC per pass.
// - Zero signature drives error low.
// - Non-zero signature drives error high.
// - Instruction 00 0001 0101 selects reference store.
// - Store writes only in user mode.
// - Error pin push-pull, optionally open-drain.
// - Error holds until a clean pass.
// - Store loading never halts checking.
// - Checking starts automatically entering user mode.
`timescale 1ns/1ps
module scc_crc_check
  import scc_pkg::*;
#(
  parameter int CELL_BITS = 1024,
  parameter int FRAME_LEN = 64,
  parameter int AW        = 10
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       reconfig_req_n,
  input  wire logic                       check_enable,
  input  wire logic                       open_drain_sel,
  input  wire scc_bit_type                cfg_in,
  input  wire logic                       cfg_crc_bit,
  input  wire logic                       cfg_ref_bit,
  input  wire logic [`SCC_INSTR_W-1:0]    tap_instr,
  input  wire scc_tap_type                tap,
  output logic                            tdo_r,
  output logic                            crc_error_o_r,
  output logic                            crc_error_oe_n_r,
  output logic                            user_mode_r,
  output logic                            frame_error_r,
  output logic [`SCC_CRC_W-1:0]           crc_result_signature_r,
  output logic [`SCC_CRC_W-1:0]           crc_reference_store_r
);
  initial begin
    if (CELL_BITS < 2 || (1 << AW) < CELL_BITS || FRAME_LEN < 1 || CELL_BITS % FRAME_LEN != 0) begin
      $error("scc_crc_check geometry is not supported");
    end
  end

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta_r;
  logic rst_n_r;
  logic rst_all_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Reconfiguration request acts as a synchronous reset of the whole checker.
  assign rst_all_n = rst_n_r & reconfig_req_n;

  // ************************************************************
  // Loading and per-frame check
  // ************************************************************
  scc_mode_type         mode_r, mode_nxt;
  logic [15:0]          fcrc_r, fcrc_nxt;
  logic [15:0]          fexp_r, fexp_nxt;
  logic [AW-1:0]        waddr_r, waddr_nxt;
  logic [31:0]          fcnt_r, fcnt_nxt;
  logic [31:0]          ref_sh_r, ref_sh_nxt;
  logic                 ferr_nxt;
  logic                 mem_we;

  // The frame CRC rides beside the data, one bit per data bit, so it is complete with the frame.
  assign mem_we = (mode_r == SCC_ST_CONFIG) && cfg_in.valid;

  always_comb begin
    mode_nxt   = mode_r;
    fcrc_nxt   = fcrc_r;
    fexp_nxt   = fexp_r;
    waddr_nxt  = waddr_r;
    fcnt_nxt   = fcnt_r;
    ref_sh_nxt = ref_sh_r;
    ferr_nxt   = frame_error_r;
    if (mem_we) begin
      fcrc_nxt   = scc_crc16_step(fcrc_r, cfg_in.data);
      fexp_nxt   = {fexp_r[14:0], cfg_crc_bit};
      ref_sh_nxt = {ref_sh_r[30:0], cfg_ref_bit};
      waddr_nxt  = waddr_r + AW'(1);
      fcnt_nxt   = fcnt_r + 32'h00000001;
      if (fcnt_r == 32'(FRAME_LEN - 1)) begin
        fcnt_nxt = 32'h00000000;
        // The compare must see the folded frame value before the seed is put back.
        if (fcrc_nxt != fexp_nxt) begin
          ferr_nxt = 1'b1;
          mode_nxt = SCC_ST_FAILED;
        end else if (cfg_in.last) begin
          mode_nxt = SCC_ST_USER;
        end
        fcrc_nxt = `SCC_FRAME_INIT;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r        <= SCC_ST_CONFIG;
      fcrc_r        <= `SCC_FRAME_INIT;
      fexp_r        <= 16'h0000;
      waddr_r       <= '0;
      fcnt_r        <= 32'h00000000;
      ref_sh_r      <= `SCC_ZERO32;
      frame_error_r <= 1'b0;
    end else if (!rst_all_n) begin
      mode_r        <= SCC_ST_CONFIG;
      fcrc_r        <= `SCC_FRAME_INIT;
      fexp_r        <= 16'h0000;
      waddr_r       <= '0;
      fcnt_r        <= 32'h00000000;
      ref_sh_r      <= `SCC_ZERO32;
      frame_error_r <= 1'b0;
    end else begin
      mode_r        <= mode_nxt;
      fcrc_r        <= fcrc_nxt;
      fexp_r        <= fexp_nxt;
      waddr_r       <= waddr_nxt;
      fcnt_r        <= fcnt_nxt;
      ref_sh_r      <= ref_sh_nxt;
      frame_error_r <= ferr_nxt;
    end
  end

  // ************************************************************
  // Cell memory and user mode passes
  // ************************************************************
  logic [AW-1:0]  raddr_r, raddr_nxt;
  logic           rd_vld_r, rd_vld_nxt;
  logic           rd_last_r, rd_last_nxt;
  logic           cell_bit;
  logic [31:0]    acc_r, acc_nxt;
  logic [31:0]    sig_nxt;
  logic           err_nxt;
  logic           running;

  // Memory blocks and I/O state never reach this array, so they are outside the sum.
  scc_cell_mem #(.DEPTH(CELL_BITS), .AW(AW)) u_cells (
    .clk   (clk),
    .we    (mem_we),
    .waddr (waddr_r),
    .wdata (cfg_in.data),
    .raddr (raddr_r),
    .rdata (cell_bit)
  );

  assign running = (mode_r == SCC_ST_USER) && check_enable;

  // The pass folds all cells and then the 32 reference bits, so a clean image leaves zero.
  always_comb begin
    raddr_nxt   = raddr_r;
    rd_vld_nxt  = 1'b0;
    rd_last_nxt = 1'b0;
    acc_nxt     = acc_r;
    sig_nxt     = crc_result_signature_r;
    err_nxt     = crc_error_o_r;
    if (running) begin
      rd_vld_nxt  = 1'b1;
      rd_last_nxt = (raddr_r == AW'(CELL_BITS - 1));
      raddr_nxt   = rd_last_nxt ? '0 : raddr_r + AW'(1);
    end
    if (rd_vld_r) begin
      acc_nxt = scc_crc32_step(acc_r, cell_bit);
      if (rd_last_r) begin
        for (int i = 31; i >= 0; i--) begin
          acc_nxt = scc_crc32_step(acc_nxt, crc_reference_store_r[i]);
        end
        sig_nxt = acc_nxt;
        err_nxt = (acc_nxt != `SCC_ZERO32);
        acc_nxt = `SCC_CRC_INIT;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      raddr_r                <= '0;
      rd_vld_r               <= 1'b0;
      rd_last_r              <= 1'b0;
      acc_r                  <= `SCC_CRC_INIT;
      crc_result_signature_r <= `SCC_ZERO32;
      crc_error_o_r          <= 1'b0;
    end else if (!rst_all_n) begin
      raddr_r                <= '0;
      rd_vld_r               <= 1'b0;
      rd_last_r              <= 1'b0;
      acc_r                  <= `SCC_CRC_INIT;
      crc_result_signature_r <= `SCC_ZERO32;
      crc_error_o_r          <= 1'b0;
    end else begin
      raddr_r                <= raddr_nxt;
      rd_vld_r               <= rd_vld_nxt;
      rd_last_r              <= rd_last_nxt;
      acc_r                  <= acc_nxt;
      crc_result_signature_r <= sig_nxt;
      crc_error_o_r          <= err_nxt;
    end
  end

  // ************************************************************
  // Error pin drive and mode flag
  // ************************************************************
  logic oe_n_nxt;

  // Open-drain only pulls low; a high level is left to the external pull-up.
  always_comb begin
    oe_n_nxt = 1'b0;
    if (open_drain_sel && err_nxt && rst_all_n) begin
      oe_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_error_oe_n_r <= 1'b0;
      user_mode_r      <= 1'b0;
    end else begin
      crc_error_oe_n_r <= oe_n_nxt;
      user_mode_r      <= rst_all_n && (mode_nxt == SCC_ST_USER);
    end
  end

  // ************************************************************
  // Reference store and its scan path
  // ************************************************************
  logic [31:0] scan_r, scan_nxt;
  logic [31:0] store_nxt;
  logic        sel;
  logic        tdo_nxt;

  assign sel = (tap_instr == `SCC_INSTR_LOAD_REF);

  // Capture loads the live store so the tester can save it before overwriting it.
  always_comb begin
    scan_nxt  = scan_r;
    store_nxt = crc_reference_store_r;
    tdo_nxt   = tdo_r;
    if (mode_r == SCC_ST_CONFIG && mode_nxt == SCC_ST_USER) begin
      store_nxt = ref_sh_nxt;
    end
    if (sel && mode_r == SCC_ST_USER) begin
      if (tap.capture) begin
        scan_nxt = crc_reference_store_r;
        tdo_nxt  = crc_reference_store_r[0];
      end else if (tap.shift) begin
        scan_nxt = {tap.tdi, scan_r[31:1]};
        tdo_nxt  = scan_r[1];
      end else if (tap.update) begin
        store_nxt = scan_r;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_r                <= `SCC_ZERO32;
      crc_reference_store_r <= `SCC_ZERO32;
      tdo_r                 <= 1'b0;
    end else if (!rst_all_n) begin
      scan_r                <= `SCC_ZERO32;
      crc_reference_store_r <= `SCC_ZERO32;
      tdo_r                 <= 1'b0;
    end else begin
      scan_r                <= scan_nxt;
      crc_reference_store_r <= store_nxt;
      tdo_r                 <= tdo_nxt;
    end
  end
endmodule

// File: dv/scc_crc_check_checker.sv
/*
  Concurrent checks on the ports of the configuration cell CRC checker.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module scc_crc_check_checker
  import scc_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire logic                    reconfig_req_n,
  input wire logic                    open_drain_sel,
  input wire logic [`SCC_INSTR_W-1:0] tap_instr,
  input wire scc_tap_type             tap,
  input wire logic                    tdo_r,
  input wire logic                    crc_error_o_r,
  input wire logic                    crc_error_oe_n_r,
  input wire logic                    user_mode_r,
  input wire logic                    frame_error_r,
  input wire logic [`SCC_CRC_W-1:0]   crc_result_signature_r,
  input wire logic [`SCC_CRC_W-1:0]   crc_reference_store_r
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_err_on_sig: assert property ((crc_result_signature_r != 32'h0) |-> ##[0:1] crc_error_o_r)
    else $error("error output low with non-zero signature");
  a_err_off_sig: assert property ((crc_result_signature_r == 32'h0) |-> ##[0:1] !crc_error_o_r)
    else $error("error output high with zero signature");
  a_err_holds: assert property (disable iff (!reset_n || !reconfig_req_n) $rose(crc_error_o_r) |-> crc_error_o_r[*8])
    else $error("error output dropped too soon");
  a_od_release: assert property (open_drain_sel && crc_error_o_r |-> ##[0:1] crc_error_oe_n_r)
    else $error("open-drain pin not released on error");
  a_pp_drive: assert property (!open_drain_sel && $past(!open_drain_sel) |-> !crc_error_oe_n_r)
    else $error("push-pull pin not driven");
  a_reconfig_clear: assert property (!reconfig_req_n |=> !user_mode_r && !crc_error_o_r
    && crc_reference_store_r == 32'h0)
    else $error("reconfiguration did not clear the checker");
  a_user_stays: assert property (user_mode_r && reconfig_req_n |=> user_mode_r)
    else $error("user mode left without reconfiguration");
  a_fail_no_user: assert property (frame_error_r |-> !user_mode_r)
    else $error("user mode entered after a frame mismatch");
  a_store_user: assert property ($changed(crc_reference_store_r) && $past(reconfig_req_n) |-> user_mode_r)
    else $error("reference store changed outside user mode");
  a_tdo_capture: assert property (tap.capture && tap_instr == `SCC_INSTR_LOAD_REF && user_mode_r
    && reconfig_req_n |=> tdo_r == $past(crc_reference_store_r[0]))
    else $error("capture did not present store bit 0");
endmodule

bind scc_crc_check scc_crc_check_checker i_scc_crc_check_checker (
  .clk                    (clk),
  .reset_n                (reset_n),
  .reconfig_req_n         (reconfig_req_n),
  .open_drain_sel         (open_drain_sel),
  .tap_instr              (tap_instr),
  .tap                    (tap),
  .tdo_r                  (tdo_r),
  .crc_error_o_r          (crc_error_o_r),
  .crc_error_oe_n_r       (crc_error_oe_n_r),
  .user_mode_r            (user_mode_r),
  .frame_error_r          (frame_error_r),
  .crc_result_signature_r (crc_result_signature_r),
  .crc_reference_store_r  (crc_reference_store_r)
);

// File: dv/scc_tap_model.sv
/*
  Test access port partner: drives instruction and data register strobes to scan the reference store.
  Assumes strobes are taken at the rising edge and tdo is settled by the falling edge.
*/
`timescale 1ns/1ps
module scc_tap_model
  import scc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               tdo_r,
  output scc_tap_type             tap,
  output logic [`SCC_INSTR_W-1:0] tap_instr
);
  initial begin
    tap = '0;
    tap_instr = '0;
  end

  // ****************************************
  // Scan task
  // ****************************************
  // Old contents come out while the new value goes in, so the store is never lost.
  task automatic scan(input logic [31:0] nv, output logic [31:0] ov);
    @(posedge clk);
    tap_instr <= `SCC_INSTR_LOAD_REF;
    tap <= '{capture: 1'b1, default: 1'b0};
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      tap <= '{shift: 1'b1, tdi: nv[i], default: 1'b0};
      @(negedge clk);
      ov[i] = tdo_r;
    end
    @(posedge clk);
    tap <= '{update: 1'b1, default: 1'b0};
    @(posedge clk);
    tap <= '0;
    tap_instr <= 10'h000;
    @(posedge clk);
  endtask
endmodule

// File: dv/test_scc_crc_check.sv
/*
  Self-checking bench: loads an image, checks passes, injects and clears a fault, reconfigures.
  Assumes the small parameter set and the tap partner model.
*/
`timescale 1ns/1ps
module test_scc_crc_check;
  import scc_pkg::*;
  localparam int CB = 64;
  localparam int FL = 16;
  logic               clk            = 1'b0;
  logic               reset_n        = 1'b0;
  logic               reconfig_req_n = 1'b1;
  logic               open_drain_sel = 1'b0;
  logic               check_enable   = 1'b1;
  scc_bit_type        cfg_in         = '0;
  logic               cfg_crc_bit    = 1'b0;
  logic               cfg_ref_bit    = 1'b0;
  scc_tap_type        tap;
  logic [9:0]         tap_instr;
  logic               tdo_r, err, oe_n, user, ferr;
  logic [31:0]        sig, store, ref_val, old;
  logic [CB-1:0]      cells = 64'h5a3c_96e1_0ff0_c3a5;
  int                 err_total  = 0;
  int                 num_checks = 0;

  always #2 clk = ~clk;

  scc_crc_check #(.CELL_BITS(CB), .FRAME_LEN(FL), .AW(6)) i_scc_crc_check (
    .clk(clk), .reset_n(reset_n), .reconfig_req_n(reconfig_req_n), .check_enable(check_enable),
    .open_drain_sel(open_drain_sel), .cfg_in(cfg_in), .cfg_crc_bit(cfg_crc_bit),
    .cfg_ref_bit(cfg_ref_bit), .tap_instr(tap_instr), .tap(tap), .tdo_r(tdo_r),
    .crc_error_o_r(err), .crc_error_oe_n_r(oe_n), .user_mode_r(user), .frame_error_r(ferr),
    .crc_result_signature_r(sig), .crc_reference_store_r(store));

  scc_tap_model i_scc_tap_model (.clk(clk), .tdo_r(tdo_r), .tap(tap), .tap_instr(tap_instr));

  task automatic print_verdict();
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ****************************************
  // Loader and waits
  // ****************************************
  // A bad load flips one frame CRC bit of the second frame.
  task automatic load(input logic bad);
    logic [15:0] fc;
    for (int i = 0; i < CB; i++) begin
      if (i % FL == 0) begin
        fc = 16'hffff;
        for (int j = 0; j < FL; j++) fc = {fc[14:0], 1'b0} ^ ((fc[15] ^ cells[i+j]) ? 16'h1021 : 16'h0);
      end
      @(posedge clk);
      cfg_in <= '{valid: 1'b1, data: cells[i], last: (i >= CB - FL)};
      cfg_crc_bit <= fc[15 - i % FL] ^ (bad && i == FL);
      cfg_ref_bit <= (i >= CB - 32) ? ref_val[CB - 1 - i] : 1'b0;
    end
    @(posedge clk);
    cfg_in <= '0;
    repeat (3) @(posedge clk);
  endtask

  task automatic wait_err(input logic e);
    for (int i = 0; i < 400 && err !== e; i++) @(posedge clk);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    ref_val = 32'hffffffff;
    for (int i = 0; i < CB; i++) ref_val = {ref_val[30:0], 1'b0} ^ ((ref_val[31] ^ cells[i]) ? 32'h04c11db7 : 32'h0);
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("user_mode", user, 0);
    load(1'b0);
    chk("user_mode", user, 1);
    chk("frame_error", ferr, 0);
    chk("store", store, ref_val);
    repeat (250) @(posedge clk);
    chk("signature", sig, 0);
    chk("error", err, 0);
    chk("oe_n", oe_n, 0);
    open_drain_sel <= 1'b1;
    check_enable <= 1'b0;
    i_scc_tap_model.scan(32'h0badf00d, old);
    chk("scan_out", old, ref_val);
    chk("store", store, 32'h0badf00d);
    repeat (150) @(posedge clk);
    chk("error", err, 0);
    check_enable <= 1'b1;
    wait_err(1'b1);
    chk("error", err, 1);
    chk("oe_n", oe_n, 1);
    chk("sig_zero", sig == 32'h0, 0);
    repeat (120) @(posedge clk);
    chk("error", err, 1);
    chk("user_mode", user, 1);
    i_scc_tap_model.scan(ref_val, old);
    chk("scan_out", old, 32'h0badf00d);
    wait_err(1'b0);
    chk("error", err, 0);
    chk("signature", sig, 0);
    chk("oe_n", oe_n, 0);
    reconfig_req_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("user_mode", user, 0);
    chk("store", store, 0);
    reconfig_req_n <= 1'b1;
    load(1'b1);
    chk("frame_error", ferr, 1);
    chk("user_mode", user, 0);
    i_scc_tap_model.scan(32'h0badf00d, old);
    chk("store", store, 0);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end
endmodule
